// [src/cmc_regs.svh]
// constants for the transceiver mode control block
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CMC_OFF_STATUS        4'h0
`define CMC_OFF_CTRL          4'h4
`define CMC_OFF_FLAG_CLR      4'h8

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CMC_ST_MODE_LSB       0
`define CMC_ST_MODE_MSB       2
`define CMC_BIT_WAKE          3
`define CMC_BIT_WSRC_LOCAL    4
`define CMC_BIT_PWON          5
`define CMC_BIT_LOCAL_FAIL    6
`define CMC_BIT_BUS_FAIL      7
`define CMC_BIT_INH_ON        8
`define CMC_CTRL_LWAKE_EN     0
`define CMC_CTRL_BWAKE_EN     1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CMC_CTRL_RESET        2'h3
`define CMC_RDATA_RESET       32'h0000_0000

// ---------------------------------------------------------------
// timing, in ns, and conversion to sys_clk cycles
// ---------------------------------------------------------------
`define CMC_CLK_PERIOD_NS     8
`define CMC_T_WAKE_PHASE_NS   5000
`define CMC_T_WAKE_WIN_NS     500000
`define CMC_T_SLEEP_HOLD_NS   50000
`define CMC_T_LWAKE_NS        50000
`define CMC_T_TXD_DOM_NS      4000
`define CMC_TXD_EDGES         3'h4
`define CMC_CYC_MIN(t) (((t) + `CMC_CLK_PERIOD_NS - 1) / `CMC_CLK_PERIOD_NS)
`define CMC_CYC_MAX(t) ((t) / `CMC_CLK_PERIOD_NS)

`endif

// [src/cmc_pkg.sv]
// types of the transceiver mode control block
package cmc_pkg;

    // ---------------------------------------------------------------
    // operating modes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL  = 3'b000,
        MODE_LISTEN  = 3'b001,
        MODE_STANDBY = 3'b010,
        MODE_GOSLEEP = 3'b011,
        MODE_SLEEP   = 3'b100
    } cmc_mode_t;

    // ---------------------------------------------------------------
    // bus wake pattern detector states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        BW_IDLE = 2'b00,
        BW_DOM1 = 2'b01,
        BW_REC  = 2'b10,
        BW_DOM2 = 2'b11
    } cmc_bw_t;

    // mode select pins
    typedef struct packed {
        logic mode_select_low;
        logic mode_select_b;
    } cmc_sel_t;

    // supply undervoltage indications, high when low
    typedef struct packed {
        logic uv_core;
        logic uv_io;
        logic uv_battery;
    } cmc_supply_t;

    // failure diagnosis results from the analog side
    typedef struct packed {
        logic local_fail;
        logic bus_fail;
    } cmc_fail_t;

    // controls toward the analog front end
    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic bias_half;
        logic bias_gnd;
        logic split_enable;
        logic wake_detect_en;
        logic local_diag_en;
        logic bus_diag_en;
    } cmc_drive_t;

endpackage : cmc_pkg

// [src/cmc_mode_ctrl.sv]
// operating mode control of a high speed can transceiver
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "cmc_regs.svh"


module cmc_mode_ctrl #(
    parameter int CW        = 17,
    parameter int PHASE_CYC = `CMC_CYC_MIN(`CMC_T_WAKE_PHASE_NS),
    parameter int WIN_CYC   = `CMC_CYC_MAX(`CMC_T_WAKE_WIN_NS),
    parameter int HOLD_CYC  = `CMC_CYC_MIN(`CMC_T_SLEEP_HOLD_NS),
    parameter int LWAKE_CYC = `CMC_CYC_MIN(`CMC_T_LWAKE_NS),
    parameter int TXDOM_CYC = `CMC_CYC_MIN(`CMC_T_TXD_DOM_NS)
) (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               srst,
    // host pins
    input  wire cmc_pkg::cmc_sel_t  mode_sel,
    input  wire logic               txd,
    output logic                    rxd,
    output logic                    fault_indicator_out,
    // supplies and diagnosis
    input  wire cmc_pkg::cmc_supply_t supply,
    input  wire cmc_pkg::cmc_fail_t fail_in,
    // bus and local wake
    input  wire logic               bus_dominant,
    input  wire logic               local_wake_in,
    // regulator inhibit, open drain toward battery
    output logic                    regulator_inhibit_out,
    output logic                    regulator_inhibit_oe,
    // analog front end controls
    output cmc_pkg::cmc_drive_t     drive,
    output cmc_pkg::cmc_mode_t      mode,
    // register port
    input  wire logic [3:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata
);
    import cmc_pkg::*;

    localparam logic [CW-1:0] PHASE_L = CW'(PHASE_CYC);
    localparam logic [CW-1:0] WIN_L   = CW'(WIN_CYC);
    localparam logic [CW-1:0] HOLD_L  = CW'(HOLD_CYC);
    localparam logic [CW-1:0] LWAKE_L = CW'(LWAKE_CYC);
    localparam logic [CW-1:0] TXDOM_L = CW'(TXDOM_CYC);

    // ---------------------------------------------------------------
    // whole state of the block
    // ---------------------------------------------------------------
    typedef struct packed {
        cmc_mode_t   mode;
        logic        msl_q;
        logic        wake;
        logic        wsrc_local;
        logic        pwon;
        logic        local_fail;
        logic        bus_fail;
        logic        listen_from_normal;
        logic [CW-1:0] hold_cnt;
        cmc_bw_t     bw;
        logic [CW-1:0] bw_ph;
        logic [CW-1:0] bw_win;
        logic        lw_primed;
        logic        lw_level;
        logic [CW-1:0] lw_cnt;
        logic        txd_q;
        logic [CW-1:0] txd_dom;
        logic [2:0]  txd_edges;
        logic [1:0]  ctrl;
        logic        rxd;
        logic        fault;
        logic        inh_oe;
        cmc_drive_t  drive;
        logic [31:0] rdata;
    } cmc_state_t;

    cmc_state_t st_ff;
    cmc_state_t nxt_st;

    // saturating counter step
    function automatic logic [CW-1:0] cmc_inc(input logic [CW-1:0] v);
        cmc_inc = (&v) ? v : v + 1'b1;
    endfunction : cmc_inc

    // true for standby, go-to-sleep and sleep
    function automatic logic cmc_low_power(input cmc_mode_t m);
        cmc_low_power = (m == MODE_STANDBY) || (m == MODE_GOSLEEP) ||
                        (m == MODE_SLEEP);
    endfunction : cmc_low_power

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic    bus_wake_evt;
        logic    local_wake_evt;
        logic    wake_evt;
        logic    msl_rise;
        logic    sup_ok;
        logic    wr_clr;
        cmc_mode_t sel_mode;
        bus_wake_evt   = 1'b0;
        local_wake_evt = 1'b0;
        wake_evt       = 1'b0;
        msl_rise       = 1'b0;
        sup_ok         = 1'b0;
        wr_clr         = 1'b0;
        sel_mode       = MODE_STANDBY;
        nxt_st         = st_ff;

        // bus wake pattern detector, runs only in low power modes
        nxt_st.bw_ph  = cmc_inc(st_ff.bw_ph);
        nxt_st.bw_win = cmc_inc(st_ff.bw_win);
        case (st_ff.bw)
            BW_IDLE: begin
                nxt_st.bw_ph  = {{(CW-1){1'b0}}, 1'b1};
                nxt_st.bw_win = {{(CW-1){1'b0}}, 1'b1};
                if (bus_dominant) begin
                    nxt_st.bw = BW_DOM1;
                end
            end
            BW_DOM1: begin
                if (!bus_dominant) begin
                    nxt_st.bw_ph = {{(CW-1){1'b0}}, 1'b1};
                    nxt_st.bw = (st_ff.bw_ph >= PHASE_L) ? BW_REC
                                                          : BW_IDLE;
                end
            end
            BW_REC: begin
                if (bus_dominant) begin
                    nxt_st.bw_ph = {{(CW-1){1'b0}}, 1'b1};
                    nxt_st.bw = (st_ff.bw_ph >= PHASE_L) ? BW_DOM2
                                                          : BW_IDLE;
                end
            end
            BW_DOM2: begin
                if (!bus_dominant) begin
                    nxt_st.bw = BW_IDLE;
                end else if (st_ff.bw_ph >= PHASE_L) begin
                    bus_wake_evt = st_ff.ctrl[`CMC_CTRL_BWAKE_EN];
                    nxt_st.bw    = BW_IDLE;
                end
            end
            default: begin
                nxt_st.bw = BW_IDLE;
            end
        endcase
        // whole pattern must finish inside the window
        if (st_ff.bw != BW_IDLE && st_ff.bw_win >= WIN_L &&
            !bus_wake_evt) begin
            nxt_st.bw = BW_IDLE;
        end
        if (!st_ff.drive.wake_detect_en) begin
            nxt_st.bw = BW_IDLE;
            bus_wake_evt = 1'b0;
        end

        // local wake filter, either edge held long enough
        if (!st_ff.lw_primed) begin
            nxt_st.lw_primed = 1'b1;
            nxt_st.lw_level  = local_wake_in;
            nxt_st.lw_cnt    = '0;
        end else if (local_wake_in == st_ff.lw_level) begin
            nxt_st.lw_cnt = '0;
        end else if (st_ff.lw_cnt >= LWAKE_L - 1'b1) begin
            nxt_st.lw_level = local_wake_in;
            nxt_st.lw_cnt   = '0;
            local_wake_evt  = st_ff.drive.wake_detect_en &&
                              st_ff.ctrl[`CMC_CTRL_LWAKE_EN];
        end else begin
            nxt_st.lw_cnt = cmc_inc(st_ff.lw_cnt);
        end
        wake_evt = bus_wake_evt || local_wake_evt;

        // mode selection
        nxt_st.msl_q = mode_sel.mode_select_low;
        msl_rise = mode_sel.mode_select_low && !st_ff.msl_q;
        case ({mode_sel.mode_select_low, mode_sel.mode_select_b})
            2'b11:   sel_mode = MODE_NORMAL;
            2'b10:   sel_mode = MODE_LISTEN;
            2'b01:   sel_mode = MODE_GOSLEEP;
            default: sel_mode = MODE_STANDBY;
        endcase

        if (st_ff.mode == MODE_GOSLEEP) begin
            nxt_st.hold_cnt = cmc_inc(st_ff.hold_cnt);
        end else begin
            nxt_st.hold_cnt = '0;
        end

        if (supply.uv_core || supply.uv_io) begin
            nxt_st.mode = MODE_SLEEP;
        end else if (supply.uv_battery) begin
            nxt_st.mode = MODE_STANDBY;
        end else if (st_ff.mode == MODE_SLEEP) begin
            if (msl_rise) begin
                nxt_st.mode = sel_mode;
            end
        end else if (st_ff.mode == MODE_GOSLEEP &&
                     sel_mode == MODE_GOSLEEP) begin
            // a pending or fresh wakeup keeps the node awake
            if (st_ff.hold_cnt >= HOLD_L - 1'b1 &&
                !st_ff.wake && !wake_evt) begin
                nxt_st.mode = MODE_SLEEP;
            end
        end else begin
            nxt_st.mode = sel_mode;
        end

        // listen entry source
        if (nxt_st.mode == MODE_LISTEN && st_ff.mode != MODE_LISTEN) begin
            nxt_st.listen_from_normal = (st_ff.mode == MODE_NORMAL);
        end
        // fresh normal entry restarts the txd edge count
        if (nxt_st.mode == MODE_NORMAL && st_ff.mode != MODE_NORMAL) begin
            nxt_st.txd_edges = '0;
            nxt_st.txd_dom   = '0;
        end else begin
            nxt_st.txd_dom = txd ? '0 : cmc_inc(st_ff.txd_dom);
            if (txd && !st_ff.txd_q && st_ff.txd_dom >= TXDOM_L &&
                st_ff.txd_edges != `CMC_TXD_EDGES) begin
                nxt_st.txd_edges = st_ff.txd_edges + 3'h1;
            end
        end
        nxt_st.txd_q = txd;

        // flags: hardware sets win over software clears
        wr_clr = reg_wr && (reg_addr == `CMC_OFF_FLAG_CLR);
        if (wr_clr && reg_wdata[`CMC_BIT_WAKE]) begin
            nxt_st.wake = 1'b0;
        end
        if (nxt_st.mode == MODE_NORMAL && st_ff.mode != MODE_NORMAL) begin
            nxt_st.wake = 1'b0;
            nxt_st.pwon = 1'b0;
        end
        if (wr_clr && reg_wdata[`CMC_BIT_PWON]) begin
            nxt_st.pwon = 1'b0;
        end
        if (wr_clr && reg_wdata[`CMC_BIT_LOCAL_FAIL]) begin
            nxt_st.local_fail = 1'b0;
        end
        if (wr_clr && reg_wdata[`CMC_BIT_BUS_FAIL]) begin
            nxt_st.bus_fail = 1'b0;
        end
        if (wake_evt) begin
            nxt_st.wake       = 1'b1;
            nxt_st.wsrc_local = local_wake_evt;
        end
        if (st_ff.drive.local_diag_en && fail_in.local_fail) begin
            nxt_st.local_fail = 1'b1;
        end
        if (st_ff.drive.bus_diag_en && fail_in.bus_fail) begin
            nxt_st.bus_fail = 1'b1;
        end

        // front end controls per mode
        nxt_st.drive = '0;
        case (nxt_st.mode)
            MODE_NORMAL: begin
                nxt_st.drive.tx_enable     = 1'b1;
                nxt_st.drive.rx_enable     = 1'b1;
                nxt_st.drive.bias_half     = 1'b1;
                nxt_st.drive.split_enable  = 1'b1;
                nxt_st.drive.local_diag_en = 1'b1;
                nxt_st.drive.bus_diag_en   = 1'b1;
            end
            MODE_LISTEN: begin
                nxt_st.drive.rx_enable     = 1'b1;
                nxt_st.drive.bias_half     = 1'b1;
                nxt_st.drive.split_enable  = 1'b1;
                nxt_st.drive.local_diag_en = 1'b1;
            end
            default: begin
                nxt_st.drive.bias_gnd       = 1'b1;
                nxt_st.drive.wake_detect_en = 1'b1;
            end
        endcase

        // inhibit floats only in sleep without a pending wakeup
        nxt_st.inh_oe = !(nxt_st.mode == MODE_SLEEP &&
                          !nxt_st.wake);

        // rxd and fault indicator
        sup_ok = !supply.uv_io && !supply.uv_battery;
        nxt_st.rxd   = 1'b1;
        nxt_st.fault = 1'b1;
        if (cmc_low_power(nxt_st.mode)) begin
            if (sup_ok) begin
                nxt_st.rxd   = !nxt_st.wake;
                nxt_st.fault = !nxt_st.wake;
            end
        end else if (nxt_st.mode == MODE_NORMAL) begin
            nxt_st.rxd = !bus_dominant;
            if (nxt_st.txd_edges == `CMC_TXD_EDGES) begin
                nxt_st.fault = !nxt_st.bus_fail;
            end else begin
                nxt_st.fault = !nxt_st.wsrc_local;
            end
        end else begin
            nxt_st.rxd = !bus_dominant;
            if (nxt_st.listen_from_normal) begin
                nxt_st.fault = !nxt_st.local_fail;
            end else begin
                nxt_st.fault = !nxt_st.pwon;
            end
        end

        // register port
        if (reg_wr && reg_addr == `CMC_OFF_CTRL) begin
            nxt_st.ctrl = reg_wdata[1:0];
        end
        nxt_st.rdata = `CMC_RDATA_RESET;
        if (reg_rd) begin
            case (reg_addr)
                `CMC_OFF_STATUS: begin
                    nxt_st.rdata[`CMC_ST_MODE_MSB:`CMC_ST_MODE_LSB] =
                        st_ff.mode;
                    nxt_st.rdata[`CMC_BIT_WAKE]       = st_ff.wake;
                    nxt_st.rdata[`CMC_BIT_WSRC_LOCAL] = st_ff.wsrc_local;
                    nxt_st.rdata[`CMC_BIT_PWON]       = st_ff.pwon;
                    nxt_st.rdata[`CMC_BIT_LOCAL_FAIL] = st_ff.local_fail;
                    nxt_st.rdata[`CMC_BIT_BUS_FAIL]   = st_ff.bus_fail;
                    nxt_st.rdata[`CMC_BIT_INH_ON]     = st_ff.inh_oe;
                end
                `CMC_OFF_CTRL: begin
                    nxt_st.rdata[1:0] = st_ff.ctrl;
                end
                default: begin
                    nxt_st.rdata = `CMC_RDATA_RESET;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_ff                    <= '0;
            st_ff.mode               <= MODE_STANDBY;
            st_ff.pwon               <= 1'b1;
            st_ff.bw                 <= BW_IDLE;
            st_ff.ctrl               <= `CMC_CTRL_RESET;
            st_ff.rxd                <= 1'b1;
            st_ff.fault              <= 1'b1;
            st_ff.inh_oe             <= 1'b1;
            st_ff.txd_q              <= 1'b1;
            st_ff.drive.bias_gnd     <= 1'b1;
            st_ff.drive.wake_detect_en <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register, except the inhibit level, which is tied high
    assign rxd                   = st_ff.rxd;
    assign fault_indicator_out   = st_ff.fault;
    assign regulator_inhibit_out = 1'b1;
    assign regulator_inhibit_oe  = st_ff.inh_oe;
    assign drive                 = st_ff.drive;
    assign mode                  = st_ff.mode;
    assign reg_rdata             = st_ff.rdata;

endmodule : cmc_mode_ctrl

// [tb/cmc_mode_ctrl_props.sv]
// checker for the transceiver mode control block
`timescale 1ns/1ps
module cmc_mode_ctrl_props #(
    parameter int HOLD_CYC = 10
) (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 srst,
    // pins and supplies
    input wire cmc_pkg::cmc_sel_t    mode_sel,
    input wire cmc_pkg::cmc_supply_t supply,
    // watched outputs
    input wire logic                 rxd,
    input wire logic                 fault_indicator_out,
    input wire logic                 regulator_inhibit_oe,
    input wire cmc_pkg::cmc_drive_t  drive,
    input wire cmc_pkg::cmc_mode_t   mode
);
    import cmc_pkg::*;
    localparam int HMIN = HOLD_CYC - 1;
    logic [7:0] gs_cnt_ff;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // counts consecutive go-to-sleep cycles
    always_ff @(posedge sys_clk) begin
        if (srst || mode != MODE_GOSLEEP) gs_cnt_ff <= 8'h00;
        else if (gs_cnt_ff != 8'hff) gs_cnt_ff <= gs_cnt_ff + 8'h01;
    end

    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    property p_uv_sleep;
        supply.uv_core || supply.uv_io |-> ##[1:2] mode == MODE_SLEEP;
    endproperty
    a_uv_sleep: assert property (p_uv_sleep)
        else $error("no sleep on core or io undervoltage");
    property p_uv_stby;
        supply == 3'h1 |-> ##[1:2] mode == MODE_STANDBY;
    endproperty
    a_uv_stby: assert property (p_uv_stby)
        else $error("no standby on battery undervoltage");
    property p_normal;
        mode == MODE_NORMAL |-> drive.tx_enable && drive.bias_half
            && !drive.wake_detect_en && drive.bus_diag_en
            && drive.local_diag_en && regulator_inhibit_oe;
    endproperty
    a_normal: assert property (p_normal)
        else $error("normal mode drive wrong");
    property p_listen;
        mode == MODE_LISTEN |-> !drive.tx_enable && drive.rx_enable
            && !drive.wake_detect_en && drive.local_diag_en
            && !drive.bus_diag_en;
    endproperty
    a_listen: assert property (p_listen)
        else $error("listen mode drive wrong");
    property p_lowpwr;
        mode inside {MODE_STANDBY, MODE_GOSLEEP, MODE_SLEEP} |->
            !drive.tx_enable && drive.bias_gnd && !drive.bias_half
            && rxd == fault_indicator_out;
    endproperty
    a_lowpwr: assert property (p_lowpwr)
        else $error("low power outputs wrong");
    property p_quiet;
        mode inside {MODE_STANDBY, MODE_SLEEP} |-> !drive.rx_enable
            && !drive.split_enable && drive.wake_detect_en;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("standby or sleep front end wrong");
    property p_inh;
        mode != MODE_SLEEP |-> regulator_inhibit_oe;
    endproperty
    a_inh: assert property (p_inh)
        else $error("inhibit floating outside sleep");
    property p_hold;
        mode == MODE_SLEEP && $past(mode) == MODE_GOSLEEP |->
            int'($past(gs_cnt_ff)) >= HMIN;
    endproperty
    a_hold: assert property (p_hold)
        else $error("sleep entered before hold time");
    property p_leave;
        mode == MODE_SLEEP && $rose(mode_sel.mode_select_low)
            && supply == 3'h0 |-> ##[1:2] mode == (mode_sel.mode_select_b
            ? MODE_NORMAL : MODE_LISTEN);
    endproperty
    a_leave: assert property (p_leave)
        else $error("sleep not left on rising select");

    // main scenarios
    c_sleep: cover property (mode == MODE_SLEEP && !regulator_inhibit_oe);
    c_wake: cover property (mode == MODE_SLEEP && regulator_inhibit_oe);
    c_listen: cover property (mode == MODE_LISTEN && !fault_indicator_out);
endmodule : cmc_mode_ctrl_props

bind cmc_mode_ctrl cmc_mode_ctrl_props #(.HOLD_CYC(HOLD_CYC)) u_props (
    .sys_clk(sys_clk), .srst(srst), .mode_sel(mode_sel),
    .supply(supply), .rxd(rxd),
    .fault_indicator_out(fault_indicator_out),
    .regulator_inhibit_oe(regulator_inhibit_oe),
    .drive(drive), .mode(mode));

// [tb/cmc_host_model.sv]
// host controller model driving mode pins and txd
`timescale 1ns/1ps
module cmc_host_model (
    // clock
    input  wire logic        sys_clk,
    // pins toward the transceiver
    output cmc_pkg::cmc_sel_t mode_sel,
    output logic             txd
);
    import cmc_pkg::*;

    // standby select and recessive txd from time zero
    initial begin
        mode_sel = 2'b00;
        txd = 1'b1;
    end

    // select a mode by pin levels
    task automatic set_sel(input logic l, input logic b);
        mode_sel <= {l, b};
    endtask : set_sel

    // hold go-to-sleep well past the sleep hold time
    task automatic go_sleep(input int cyc);
        mode_sel <= 2'b01;
        repeat (cyc) @(posedge sys_clk);
        #1;
    endtask : go_sleep

    // dominant pulses of len cycles, each ended by a rising edge
    task automatic txd_pulses(input int n, input int len);
        repeat (n) begin
            txd <= 1'b0;
            repeat (len) @(posedge sys_clk);
            #1;
            txd <= 1'b1;
            repeat (2) @(posedge sys_clk);
            #1;
        end
    endtask : txd_pulses
endmodule : cmc_host_model

// [tb/cmc_mode_ctrl_bench.sv]
// self-checking bench for the transceiver mode control block
`timescale 1ns/1ps
module cmc_mode_ctrl_bench;
    import cmc_pkg::*;
    localparam int PH = 4;
    localparam int HD = 10;
    localparam int LW = 3;
    localparam int TD = 3;
    logic        sys_clk, srst, txd, rxd, fault, inh_out, inh_oe;
    logic        bus_dominant, local_wake_in, reg_wr, reg_rd;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    cmc_sel_t    mode_sel;
    cmc_supply_t supply;
    cmc_fail_t   fail_in;
    cmc_drive_t  drive;
    cmc_mode_t   mode;
    int          n_fail, n_checks, cyc;

    cmc_host_model host (.sys_clk(sys_clk), .mode_sel(mode_sel),
        .txd(txd));
    cmc_mode_ctrl #(.PHASE_CYC(PH), .WIN_CYC(40), .HOLD_CYC(HD),
        .LWAKE_CYC(LW), .TXDOM_CYC(TD)) dut (
        .sys_clk(sys_clk), .srst(srst), .mode_sel(mode_sel), .txd(txd),
        .rxd(rxd), .fault_indicator_out(fault), .supply(supply),
        .fail_in(fail_in), .bus_dominant(bus_dominant),
        .local_wake_in(local_wake_in), .regulator_inhibit_out(inh_out),
        .regulator_inhibit_oe(inh_oe), .drive(drive), .mode(mode),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ---------------------------------------------------------------
    // clock, timeout and shared tasks
    // ---------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask : chk
    task automatic st(input cmc_mode_t m, input logic r, input logic f);
        chk({27'h0, mode, rxd, fault}, {27'h0, m, r, f});
    endtask : st
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        chk(reg_rdata, exp);
        tick(1);
    endtask : rd
    task automatic dom(input logic v);
        bus_dominant <= v;
        tick(PH + 1);
    endtask : dom

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        srst = 1'b1; supply = 3'h0; fail_in = 2'h0; bus_dominant = 1'b0;
        local_wake_in = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0; reg_rd = 1'b0; n_fail = 0; n_checks = 0; cyc = 0;
        tick(8);
        srst <= 1'b0;
        tick(1);
        st(MODE_STANDBY, 1'b1, 1'b1);
        chk({24'h0, drive}, 32'h0000_0014);
        chk({30'h0, inh_out, inh_oe}, 32'h0000_0003);
        rd(4'h0, 32'h0000_0122);
        wr(4'h0, 32'hffff_ffff);
        wr(4'hc, 32'hffff_ffff);
        rd(4'h0, 32'h0000_0122);
        rd(4'hc, 32'h0000_0000);
        wr(4'h4, 32'h0000_0000);
        rd(4'h4, 32'h0000_0000);
        wr(4'h4, 32'h0000_0003);
        rd(4'h4, 32'h0000_0003);
        $display("test reset and registers done");
        host.set_sel(1'b1, 1'b1);
        tick(3);
        st(MODE_NORMAL, 1'b1, 1'b1);
        chk({24'h0, drive}, 32'h0000_00eb);
        bus_dominant <= 1'b1;
        tick(2);
        st(MODE_NORMAL, 1'b0, 1'b1);
        bus_dominant <= 1'b0;
        fail_in <= 2'b01;
        host.txd_pulses(3, TD + 1);
        st(MODE_NORMAL, 1'b1, 1'b1);
        host.txd_pulses(1, TD + 1);
        st(MODE_NORMAL, 1'b1, 1'b0);
        rd(4'h0, 32'h0000_0180);
        fail_in <= 2'b00;
        wr(4'h8, 32'h0000_0080);
        tick(2);
        st(MODE_NORMAL, 1'b1, 1'b1);
        $display("test normal done");
        host.set_sel(1'b1, 1'b0);
        fail_in <= 2'b10;
        tick(3);
        st(MODE_LISTEN, 1'b1, 1'b0);
        chk({24'h0, drive}, 32'h0000_006a);
        fail_in <= 2'b00;
        wr(4'h8, 32'h0000_0040);
        tick(2);
        st(MODE_LISTEN, 1'b1, 1'b1);
        $display("test listen done");
        host.set_sel(1'b0, 1'b0);
        tick(3);
        local_wake_in <= 1'b1;
        tick(LW + 3);
        st(MODE_STANDBY, 1'b0, 1'b0);
        rd(4'h0, 32'h0000_011a);
        host.set_sel(1'b1, 1'b1);
        tick(3);
        st(MODE_NORMAL, 1'b1, 1'b0);
        $display("test local wake done");
        host.go_sleep(HD + 4);
        st(MODE_SLEEP, 1'b1, 1'b1);
        chk({31'h0, inh_oe}, 32'h0000_0000);
        dom(1'b1);
        dom(1'b0);
        dom(1'b1);
        bus_dominant <= 1'b0;
        tick(3);
        st(MODE_SLEEP, 1'b0, 1'b0);
        chk({31'h0, inh_oe}, 32'h0000_0001);
        rd(4'h0, 32'h0000_010c);
        host.set_sel(1'b1, 1'b0);
        tick(3);
        st(MODE_LISTEN, 1'b1, 1'b1);
        $display("test sleep and bus wake done");
        supply <= 3'b001;
        tick(3);
        st(MODE_STANDBY, 1'b1, 1'b1);
        supply <= 3'b000;
        tick(3);
        supply <= 3'b100;
        tick(3);
        st(MODE_SLEEP, 1'b0, 1'b0);
        supply <= 3'b000;
        host.set_sel(1'b0, 1'b0);
        tick(2);
        host.set_sel(1'b1, 1'b1);
        tick(3);
        st(MODE_NORMAL, 1'b1, 1'b1);
        $display("test undervoltage done");
        host.set_sel(1'b0, 1'b0);
        tick(3);
        local_wake_in <= 1'b0;
        tick(LW + 3);
        st(MODE_STANDBY, 1'b0, 1'b0);
        host.go_sleep(HD + 4);
        st(MODE_GOSLEEP, 1'b0, 1'b0);
        chk({31'h0, inh_oe}, 32'h0000_0001);
        $display("test wake beats go-to-sleep done");
        stop_test();
    end
endmodule : cmc_mode_ctrl_bench
